//--- common/asa_pkg.sv
// Shared constants for the alarm status aggregator
package asa_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_REF      = 4;
   localparam int NUM_DPLL     = 2;
   localparam int NUM_GPIO     = 4;
   localparam int ALM_PER_REF  = 3;
   localparam int ALM_PER_DPLL = 2;
   localparam int ST_W         = 3;
   localparam int ADDR_W       = 8;

   // ------------------------------------------------------------
   // Alarm positions inside a block
   // ------------------------------------------------------------
   localparam int ALM_FREQ = 0;
   localparam int ALM_LOS  = 1;
   localparam int ALM_ACT  = 2;
   localparam int ALM_HOLD = 0;
   localparam int ALM_LOCK = 1;

   // ------------------------------------------------------------
   // Digital PLL state codes
   // ------------------------------------------------------------
   localparam logic [2:0] DST_FREERUN  = 3'h0;
   localparam logic [2:0] DST_ACQUIRE  = 3'h1;
   localparam logic [2:0] DST_LOCKED   = 3'h3;
   localparam logic [2:0] DST_HOLDOVER = 3'h4;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_LIVE     = 8'h04;
   localparam logic [7:0] OFF_STK      = 8'h08;
   localparam logic [7:0] OFF_STK_CLR  = 8'h0C;
   localparam logic [7:0] OFF_BLK      = 8'h10;
   localparam logic [7:0] OFF_BLK_CLR  = 8'h14;
   localparam logic [7:0] OFF_DSTATE   = 8'h18;
   localparam logic [7:0] OFF_ALERT_EN = 8'h1C;
   localparam logic [7:0] OFF_GPIO_CFG = 8'h20;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int CTRL_GLB_EN  = 0;
   localparam int GCFG_W       = 8;
   localparam int GCFG_MODE_LSB = 0;
   localparam int GCFG_SEL_LSB = 4;
   localparam logic [2:0] GM_OFF   = 3'h0;
   localparam logic [2:0] GM_LOS   = 3'h1;
   localparam logic [2:0] GM_LOL   = 3'h2;
   localparam logic [2:0] GM_HOLD  = 3'h3;
   localparam logic [2:0] GM_ALERT = 3'h4;
   localparam logic       GLB_EN_RST   = 1'b0;
   localparam logic [31:0] ALERT_EN_RST = 32'h0000_0000;
   localparam logic [31:0] GCFG_RST     = 32'h0000_0000;
endpackage : asa_pkg

//--- rtl/asa_live_sr.sv
// Set/negate holder for reference monitor live alarms
`timescale 1ns/1ps
`default_nettype none
module asa_live_sr #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Monitor reports
   input  wire logic [W-1:0] assert_ev,
   input  wire logic [W-1:0] negate_ev,
   // Live state
   output logic      [W-1:0] live
);
   typedef struct packed {
      logic [W-1:0] live;
   } asa_sr_st_t;

   asa_sr_st_t st_ff;
   asa_sr_st_t nxt_st;

   // Assert wins over negate; between reports the level holds
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.live = assert_ev | (st_ff.live & ~negate_ev);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign live = st_ff.live;
endmodule : asa_live_sr
`default_nettype wire

//--- rtl/asa_sticky.sv
// Change-detecting sticky bits with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module asa_sticky #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Live alarms and clear strobes
   input  wire logic [W-1:0] live,
   input  wire logic [W-1:0] clr,
   // Sticky state
   output logic      [W-1:0] sticky
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] sticky;
   } asa_stk_st_t;

   asa_stk_st_t st_ff;
   asa_stk_st_t nxt_st;

   // Either edge of live sets the bit; a change in a clear cycle survives
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.prev   = live;
      nxt_st.sticky = (st_ff.sticky & ~clr) | (live ^ st_ff.prev);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign sticky = st_ff.sticky;
endmodule : asa_sticky
`default_nettype wire

//--- rtl/asa_top.sv
// Alarm status aggregator: live/sticky alarms, GPIO alarm pins, AHB-Lite registers
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module asa_top #(
   parameter int NR = asa_pkg::NUM_REF,
   parameter int ND = asa_pkg::NUM_DPLL,
   parameter int NG = asa_pkg::NUM_GPIO
) (
   // Clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic      [31:0]        hrdata,
   output logic                    hresp,
   // Reference monitor reports
   input  wire logic [NR-1:0]      freq_reject,
   input  wire logic [NR-1:0]      freq_accept,
   input  wire logic [NR-1:0]      period_over,
   input  wire logic [NR-1:0]      period_under,
   input  wire logic [NR-1:0]      activity_above,
   input  wire logic [NR-1:0]      activity_below,
   // Digital PLL states and analog PLL lock
   input  wire logic [ND*3-1:0]    dpll_state,
   input  wire logic               apll_locked,
   // Alarm GPIO pins
   output logic      [NG-1:0]      gpio_out,
   output logic      [NG-1:0]      gpio_oe
);
   localparam int NA = asa_pkg::ALM_PER_REF * NR + asa_pkg::ALM_PER_DPLL * ND;
   localparam int NB = NR + ND;
   localparam int DB = asa_pkg::ALM_PER_REF * NR;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       wr_addr;
      logic             wr_pend;
      logic [31:0]      rdata;
      logic             rdy;
      logic             resp;
      logic             glb_en;
      logic [NA-1:0]    alert_en;
      logic [NG*8-1:0]  gcfg;
      logic [NB-1:0]    blk;
      logic [NG-1:0]    gout;
      logic [NG-1:0]    goe;
   } asa_st_t;

   asa_st_t st_ff;
   asa_st_t nxt_st;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] widen(input logic [NA-1:0] v);
      logic [31:0] r;
      r = '0;
      r[NA-1:0] = v;
      return r;
   endfunction : widen

   function automatic logic dpll_in(input logic [ND*3-1:0] s, input int d,
                                    input logic [2:0] code);
      return s[d*3 +: 3] == code;
   endfunction : dpll_in

   // ------------------------------------------------------------
   // Live alarms
   // ------------------------------------------------------------
   logic [DB-1:0] ref_set;
   logic [DB-1:0] ref_neg;
   logic [DB-1:0] ref_live;
   logic [NA-1:0] live;
   logic [NA-1:0] sticky;
   logic [NA-1:0] stk_clr;
   logic [NB-1:0] blk_clr;
   logic [NB-1:0] blk_any;

   always_comb
   begin
      for (int r = 0; r < NR; r++)
      begin
         ref_set[3*r + asa_pkg::ALM_FREQ] = freq_reject[r];
         ref_neg[3*r + asa_pkg::ALM_FREQ] = freq_accept[r];
         ref_set[3*r + asa_pkg::ALM_LOS]  = period_over[r];
         ref_neg[3*r + asa_pkg::ALM_LOS]  = period_under[r];
         ref_set[3*r + asa_pkg::ALM_ACT]  = activity_above[r];
         ref_neg[3*r + asa_pkg::ALM_ACT]  = activity_below[r];
      end
   end

   asa_live_sr #(
      .W (DB)
   ) u_live (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .assert_ev (ref_set),
      .negate_ev (ref_neg),
      .live      (ref_live)
   );

   // PLL live bits are decoded straight from the state, no latching
   always_comb
   begin
      live[DB-1:0] = ref_live;
      for (int d = 0; d < ND; d++)
      begin
         live[DB + 2*d + asa_pkg::ALM_HOLD] =
            dpll_in(dpll_state, d, asa_pkg::DST_HOLDOVER);
         live[DB + 2*d + asa_pkg::ALM_LOCK] =
            dpll_in(dpll_state, d, asa_pkg::DST_LOCKED) & apll_locked;
      end
   end

   // ------------------------------------------------------------
   // Sticky bits
   // ------------------------------------------------------------
   // Clears act in the write data phase, when hwdata is valid
   always_comb
   begin
      stk_clr = '0;
      blk_clr = '0;
      if (st_ff.wr_pend && st_ff.wr_addr == asa_pkg::OFF_STK_CLR)
         stk_clr = hwdata[NA-1:0];
      if (st_ff.wr_pend && st_ff.wr_addr == asa_pkg::OFF_BLK_CLR)
         blk_clr = hwdata[NB-1:0];
   end

   asa_sticky #(
      .W (NA)
   ) u_sticky (
      .hclk    (hclk),
      .hresetn (hresetn),
      .live    (live),
      .clr     (stk_clr),
      .sticky  (sticky)
   );

   // Any alarm sticky still set keeps re-raising its block sticky
   always_comb
   begin
      for (int r = 0; r < NR; r++)
         blk_any[r] = |sticky[3*r +: 3];
      for (int d = 0; d < ND; d++)
         blk_any[NR + d] = |sticky[DB + 2*d +: 2];
   end

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   function automatic logic [31:0] reg_read(input logic [7:0] a,
                                            input asa_st_t s,
                                            input logic [NA-1:0] lv,
                                            input logic [NA-1:0] sk);
      logic [31:0] r;
      r = '0;
      case (a)
         asa_pkg::OFF_CTRL:     r[asa_pkg::CTRL_GLB_EN] = s.glb_en;
         asa_pkg::OFF_LIVE:     r = widen(lv);
         asa_pkg::OFF_STK:      r = widen(sk);
         asa_pkg::OFF_BLK:      r[NB-1:0] = s.blk;
         asa_pkg::OFF_DSTATE:   r[ND*3-1:0] = dpll_state;
         asa_pkg::OFF_ALERT_EN: r = widen(s.alert_en);
         asa_pkg::OFF_GPIO_CFG: r[NG*8-1:0] = s.gcfg;
         default:               r = '0;
      endcase
      return r;
   endfunction : reg_read

   // ------------------------------------------------------------
   // Alarm output selection
   // ------------------------------------------------------------
   logic          alert;
   logic [NG-1:0] pin_val;
   logic [NG-1:0] pin_en;

   // Block stickies only count for blocks with an enabled alarm
   always_comb
   begin
      alert = |(sticky & st_ff.alert_en);
      for (int r = 0; r < NR; r++)
         if (|st_ff.alert_en[3*r +: 3] && st_ff.blk[r])
            alert = 1'b1;
      for (int d = 0; d < ND; d++)
         if (|st_ff.alert_en[DB + 2*d +: 2] && st_ff.blk[NR + d])
            alert = 1'b1;
   end

   always_comb
   begin
      logic [2:0] mode;
      logic [2:0] sel;
      mode = '0;
      sel  = '0;
      for (int g = 0; g < NG; g++)
      begin
         mode = st_ff.gcfg[g*8 + asa_pkg::GCFG_MODE_LSB +: 3];
         sel  = st_ff.gcfg[g*8 + asa_pkg::GCFG_SEL_LSB +: 3];
         pin_en[g]  = 1'b1;
         pin_val[g] = 1'b0;
         case (mode)
            asa_pkg::GM_LOS:
               if (int'(sel) < NR)
                  pin_val[g] = live[3*sel + asa_pkg::ALM_LOS];
            asa_pkg::GM_LOL:
               if (int'(sel) < ND)
                  pin_val[g] = sticky[DB + 2*sel + asa_pkg::ALM_LOCK]
                               | st_ff.blk[NR + int'(sel)];
            asa_pkg::GM_HOLD:
               if (int'(sel) < ND)
                  pin_val[g] = sticky[DB + 2*sel + asa_pkg::ALM_HOLD]
                               | st_ff.blk[NR + int'(sel)];
            asa_pkg::GM_ALERT:
               pin_val[g] = alert;
            default:
               pin_en[g] = 1'b0;
         endcase
         if (!st_ff.glb_en)
            pin_val[g] = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Bus slave and register update
   // ------------------------------------------------------------
   logic       acc;
   logic [7:0] acc_addr;

   assign acc      = hsel && hready && htrans[1];
   assign acc_addr = haddr[asa_pkg::ADDR_W-1:0];

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.rdy  = 1'b1;
      nxt_st.resp = 1'b0;
      nxt_st.blk  = (st_ff.blk & ~blk_clr) | blk_any;
      nxt_st.gout = pin_val;
      nxt_st.goe  = pin_en;
      if (st_ff.wr_pend)
      begin
         case (st_ff.wr_addr)
            asa_pkg::OFF_CTRL:
               nxt_st.glb_en = hwdata[asa_pkg::CTRL_GLB_EN];
            asa_pkg::OFF_ALERT_EN:
               nxt_st.alert_en = hwdata[NA-1:0];
            asa_pkg::OFF_GPIO_CFG:
               nxt_st.gcfg = hwdata[NG*8-1:0];
            default:
               nxt_st.glb_en = st_ff.glb_en;
         endcase
      end
      nxt_st.wr_pend = acc && hwrite;
      if (acc)
         nxt_st.wr_addr = acc_addr;
      // Read data is sampled at the address edge: the instantaneous value
      if (acc && !hwrite)
         nxt_st.rdata = reg_read(acc_addr, st_ff, live, sticky);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff          <= '0;
         st_ff.glb_en   <= asa_pkg::GLB_EN_RST;
         st_ff.alert_en <= asa_pkg::ALERT_EN_RST[NA-1:0];
         st_ff.gcfg     <= asa_pkg::GCFG_RST[NG*8-1:0];
      end
      else
         st_ff <= nxt_st;
   end

   assign hreadyout = st_ff.rdy;
   assign hrdata    = st_ff.rdata;
   assign hresp     = st_ff.resp;
   assign gpio_out  = st_ff.gout;
   assign gpio_oe   = st_ff.goe;
endmodule : asa_top
`default_nettype wire

//--- tb/asa_mon_model.sv
// Behavioural reference monitors feeding the aggregator
`timescale 1ns/1ps
`default_nettype none
module asa_mon_model (
   // Wanted alarm state, three bits per reference
   input  wire logic [11:0] want,
   // Monitor reports
   output logic      [3:0]  freq_reject,
   output logic      [3:0]  freq_accept,
   output logic      [3:0]  period_over,
   output logic      [3:0]  period_under,
   output logic      [3:0]  activity_above,
   output logic      [3:0]  activity_below
);
   // -------------------------------------------------------------
   // Reports
   // -------------------------------------------------------------
   // Assert and negate reports never overlap, so no precedence is leaned on
   always_comb
   begin
      for (int r = 0; r < 4; r++)
      begin
         freq_reject[r]    = want[3*r];
         freq_accept[r]    = ~want[3*r];
         period_over[r]    = want[3*r+1];
         period_under[r]   = ~want[3*r+1];
         activity_above[r] = want[3*r+2];
         activity_below[r] = ~want[3*r+2];
      end
   end
endmodule : asa_mon_model
`default_nettype wire

//--- tb/asa_top_sva.sv
// Port-level assertions for the alarm status aggregator
`timescale 1ns/1ps
`default_nettype none
module asa_top_sva #(
   parameter int NR = asa_pkg::NUM_REF,
   parameter int ND = asa_pkg::NUM_DPLL,
   parameter int NG = asa_pkg::NUM_GPIO
) (
   // Clock and reset
   input wire logic          hclk,
   input wire logic          hresetn,
   // Bus
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic          hreadyout,
   input wire logic [31:0]   hrdata,
   input wire logic          hresp,
   // Alarm sources
   input wire logic [NR-1:0] freq_reject,
   input wire logic [NR-1:0] freq_accept,
   input wire logic [NR-1:0] period_over,
   input wire logic [NR-1:0] period_under,
   input wire logic [NR-1:0] activity_above,
   input wire logic [NR-1:0] activity_below,
   input wire logic [ND*3-1:0] dpll_state,
   input wire logic          apll_locked,
   // Pins
   input wire logic [NG-1:0] gpio_out,
   input wire logic [NG-1:0] gpio_oe
);
   // -------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------
   logic       rd_go;
   logic       rd_live;
   logic       wr_ph_ff;
   logic [7:0] wa_ff;
   logic       glb_ff;
   assign rd_go   = hsel && hready && htrans[1] && !hwrite;
   assign rd_live = rd_go && haddr[7:0] == asa_pkg::OFF_LIVE;
   // Shadow of the global enable, landing on the data-phase edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ph_ff <= 1'h0;
         wa_ff    <= 8'h00;
         glb_ff   <= 1'h0;
      end
      else
      begin
         wr_ph_ff <= hsel && hready && htrans[1] && hwrite;
         wa_ff    <= haddr[7:0];
         if (wr_ph_ff && wa_ff == asa_pkg::OFF_CTRL)
            glb_ff <= hwdata[0];
      end
   end
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   bus_ready_a: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low");
   okay_resp_a: assert property (hresp == 1'h0)
      else $error("hresp not okay");
   state_read_a: assert property (rd_go && haddr[7:0] == asa_pkg::OFF_DSTATE
      |=> hrdata[ND*3-1:0] == $past(dpll_state)) else $error("pll state read wrong");
   clr_read_a: assert property (rd_go && haddr[7:0] == asa_pkg::OFF_STK_CLR
      |=> hrdata == 32'h0) else $error("clear register read not zero");
   hold_live_a: assert property (rd_live |=>
      hrdata[12] == ($past(dpll_state[2:0]) == asa_pkg::DST_HOLDOVER)) else $error("holdover live");
   lock_live_a: assert property (rd_live |=> hrdata[13] ==
      ($past(dpll_state[2:0]) == asa_pkg::DST_LOCKED && $past(apll_locked))) else $error("lock live");
   los_set_a: assert property (rd_live && $past(hresetn) && $past(period_over[0])
      |=> hrdata[1]) else $error("loss live not set");
   freq_clr_a: assert property (rd_live && $past(hresetn) && $past(freq_accept[0])
      && !$past(freq_reject[0]) |=> !hrdata[0]) else $error("freq live not clear");
   glb_gate_a: assert property (!glb_ff && !$past(glb_ff) |-> gpio_out == '0)
      else $error("pin driven while disabled");
   oe_gate_a: assert property ((gpio_out & ~gpio_oe) == '0)
      else $error("pin high without enable");
endmodule : asa_top_sva
bind asa_top asa_top_sva #(.NR(NR), .ND(ND), .NG(NG)) asa_top_sva_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .freq_reject(freq_reject),
   .freq_accept(freq_accept), .period_over(period_over), .period_under(period_under),
   .activity_above(activity_above), .activity_below(activity_below),
   .dpll_state(dpll_state), .apll_locked(apll_locked), .gpio_out(gpio_out),
   .gpio_oe(gpio_oe));
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the alarm status aggregator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic [11:0] w; logic [5:0] ds; logic ap; logic [15:0] live;} asa_row_t;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, apll_locked;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [5:0]  dpll_state;
   logic [11:0] want;
   logic [3:0]  gpio_out, gpio_oe, f_rj, f_ac, p_ov, p_un, a_ab, a_be;
   logic [15:0] stk, prev;
   int          mismatches = 0, compares = 0, cycles = 0;
   // Rows: wanted ref alarms, pll states {sys, main}, analog lock, live word
   asa_row_t rows [5] = '{'{12'h000, 6'h1B, 1'h1, 16'hA000}, '{12'h002, 6'h1B, 1'h0, 16'h0002},
      '{12'hFFF, 6'h0C, 1'h1, 16'h1FFF}, '{12'h000, 6'h20, 1'h1, 16'h4000},
      '{12'h481, 6'h03, 1'h1, 16'h2481}};
   logic [7:0] zero_regs [7] = '{asa_pkg::OFF_CTRL, asa_pkg::OFF_STK, asa_pkg::OFF_BLK,
      asa_pkg::OFF_STK_CLR, asa_pkg::OFF_ALERT_EN, asa_pkg::OFF_GPIO_CFG, 8'h40};

   asa_mon_model asa_mon_model_inst (.want(want), .freq_reject(f_rj), .freq_accept(f_ac),
      .period_over(p_ov), .period_under(p_un), .activity_above(a_ab), .activity_below(a_be));
   asa_top asa_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .freq_reject(f_rj),
      .freq_accept(f_ac), .period_over(p_ov), .period_under(p_un), .activity_above(a_ab),
      .activity_below(a_be), .dpll_state(dpll_state), .apll_locked(apll_locked),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe));

   initial
   begin
      hclk = 1'h0;
      forever #12.5 hclk = ~hclk;
   end
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : compare

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= 1'h1;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
   endtask : bus_wr

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      htrans <= 2'h2;
      hwrite <= 1'h0;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      compare(name, exp, hrdata);
   endtask : rd_chk

   // Sticky pin modes settle within four edges of the cause
   task automatic pin_chk(input logic [3:0] exp);
      repeat (4) @(posedge hclk);
      compare("gpio_out", {28'h0, exp}, {28'h0, gpio_out});
   endtask : pin_chk

   function automatic logic [31:0] blk_of(input logic [15:0] s);
      blk_of = 32'h0;
      for (int r = 0; r < 4; r++) blk_of[r] = |s[3*r +: 3];
      for (int d = 0; d < 2; d++) blk_of[4+d] = |s[12+2*d +: 2];
   endfunction : blk_of

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         summarize();
      end
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      hresetn = 1'h0; htrans = 2'h0; hwrite = 1'h0; haddr = 32'h0; hwdata = 32'h0;
      want = 12'h000; dpll_state = 6'h00; apll_locked = 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      foreach (zero_regs[i]) rd_chk("reset value", zero_regs[i], 32'h0);
      prev = 16'h0;
      stk = 16'h0;
      foreach (rows[i])
      begin
         want <= rows[i].w;
         dpll_state <= rows[i].ds;
         apll_locked <= rows[i].ap;
         repeat (2) @(posedge hclk);
         rd_chk("live", asa_pkg::OFF_LIVE, {16'h0, rows[i].live});
         stk |= rows[i].live ^ prev;
         prev = rows[i].live;
      end
      rd_chk("sticky", asa_pkg::OFF_STK, {16'h0, stk});
      rd_chk("block", asa_pkg::OFF_BLK, blk_of(stk));
      rd_chk("pll state", asa_pkg::OFF_DSTATE, 32'h0000_0003);
      bus_wr(asa_pkg::OFF_STK_CLR, 32'h0000_0F0F);
      @(posedge hclk);
      rd_chk("sticky", asa_pkg::OFF_STK, {16'h0, stk & 16'hF0F0});
      bus_wr(asa_pkg::OFF_BLK_CLR, 32'h0000_003F);
      @(posedge hclk);
      rd_chk("block", asa_pkg::OFF_BLK, blk_of(stk & 16'hF0F0));
      bus_wr(asa_pkg::OFF_STK_CLR, 32'h0000_FFFF);
      bus_wr(asa_pkg::OFF_BLK_CLR, 32'h0000_003F);
      @(posedge hclk);
      rd_chk("block", asa_pkg::OFF_BLK, 32'h0);
      // Main pll leaves lock on the edge that the clear lands
      fork
         bus_wr(asa_pkg::OFF_STK_CLR, 32'h0000_3000);
         begin
            @(posedge hclk);
            dpll_state <= 6'h04;
         end
      join
      @(posedge hclk);
      rd_chk("sticky", asa_pkg::OFF_STK, 32'h0000_3000);
      bus_wr(asa_pkg::OFF_STK_CLR, 32'h0000_FFFF);
      bus_wr(asa_pkg::OFF_BLK_CLR, 32'h0000_003F);
      bus_wr(asa_pkg::OFF_GPIO_CFG, 32'h0403_0201);
      bus_wr(asa_pkg::OFF_ALERT_EN, 32'h0000_0002);
      rd_chk("gpio cfg", asa_pkg::OFF_GPIO_CFG, 32'h0403_0201);
      want <= 12'h483;
      pin_chk(4'h0);
      compare("gpio_oe", 32'hF, {28'h0, gpio_oe});
      bus_wr(asa_pkg::OFF_CTRL, 32'h0000_0001);
      pin_chk(4'h9);
      want <= 12'h481;
      pin_chk(4'h8);
      dpll_state <= 6'h03;
      pin_chk(4'hE);
      bus_wr(asa_pkg::OFF_CTRL, 32'h0000_0000);
      pin_chk(4'h0);
      bus_wr(asa_pkg::OFF_CTRL, 32'h0000_0001);
      bus_wr(asa_pkg::OFF_STK_CLR, 32'h0000_FFFF);
      pin_chk(4'hE);
      bus_wr(asa_pkg::OFF_BLK_CLR, 32'h0000_003F);
      pin_chk(4'h0);
      // Reset in mid-run with alarms still present at the inputs
      hresetn <= 1'h0;
      @(posedge hclk);
      compare("gpio_out", 32'h0, {28'h0, gpio_out});
      hresetn <= 1'h1;
      rd_chk("ctrl after reset", asa_pkg::OFF_CTRL, 32'h0);
      compare("gpio_oe", 32'h0, {28'h0, gpio_oe});
      rd_chk("sticky after reset", asa_pkg::OFF_STK, 32'h0000_2481);
      summarize();
   end
endmodule : testbench
`default_nettype wire
